// ### core/ted_code_conv.sv
// Memory code to tape code conversion, both directions, combinational.
// Assumes the caller registers the results.
`timescale 1ns/1ps
`include "ted_regs.svh"

module ted_code_conv (
    input wire logic decimal_i,
    input wire logic [5:0] mem_code_i,
    input wire logic [5:0] tape_code_i,
    output logic [5:0] tape_code_o,
    output logic [5:0] mem_code_o
);

    // Codes with bit 4 set (hex zones 1x and 3x) trade places; the zero code is special
    function automatic logic [5:0] zone_swap(input logic [5:0] code, input logic [5:0] from,
                                              input logic [5:0] to);
        logic [5:0] result;
        result = code;
        if (code == from) begin
            result = to;
        end else if (code[`TED_ZONE_SEL_BIT]) begin
            result[`TED_ZONE_SWAP_BIT] = ~code[`TED_ZONE_SWAP_BIT];
        end
        return result;
    endfunction

    wire logic [5:0] mem_to_tape = zone_swap(mem_code_i, `TED_MEM_ZERO, `TED_TAPE_ZERO);
    wire logic [5:0] tape_to_mem = zone_swap(tape_code_i, `TED_TAPE_ZERO, `TED_MEM_ZERO);

    assign tape_code_o = decimal_i ? mem_to_tape : mem_code_i;
    assign mem_code_o = decimal_i ? tape_to_mem : tape_code_i;

endmodule

// ### core/ted_error_detector.sv
// Tape error detector: longitudinal parity check on read, character and
// longitudinal parity checks on read-after-write, amplitude error timing, one error one-shot.
// Assumes tape pins are asynchronous and software on classic Wishbone.
//
// Summary of operation
// - All detected errors fire one error one-shot sent to the buffer channel.
// - On read, set longitudinal accumulator bits after the record mean error.
// - Error one-shot drops 10 microseconds after trigger.
// - Longitudinal checks happen only when the gap timer confirms check character.
// - During write, seven capture bits toggle on each read-back one bit.
// - Binary mode: alternator toggles per character; even combined parity is error.
// - Decimal mode: odd count of ones in capture bits is error.
// - On write, set capture bits after record and check character mean error.
// - During write, low amplitude starts the 10 microsecond amplitude timer.
// - Marginal read signal during write reports through the error one-shot.
// - Decimal mode converts memory and tape codes, zero and zone swap.
// - Mode bit set selects decimal even parity, clear selects binary odd.
`timescale 1ns/1ps
`include "ted_regs.svh"

module ted_error_detector (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic write_mode_i,
    input wire logic gap_check_timer_i,
    input wire logic read_strobe_i,
    input wire logic check_strobe_i,
    input wire logic amp_sense_i,
    input wire logic [6:0] read_char_i,
    output logic error_pulse_o,
    output logic amplitude_error_timer_o
);

    // ==========================================================
    // Pin synchroniser
    ted_pkg::ted_pins_t pins_raw;
    ted_pkg::ted_pins_t pins_meta;
    ted_pkg::ted_pins_t pins_sync;
    ted_pkg::ted_pins_t pins_prev;

    assign pins_raw.write_mode = write_mode_i;
    assign pins_raw.gap_check_timer = gap_check_timer_i;
    assign pins_raw.read_strobe = read_strobe_i;
    assign pins_raw.check_strobe = check_strobe_i;
    assign pins_raw.amp_sense = amp_sense_i;
    assign pins_raw.read_char = read_char_i;

    // Data and strobes share one synchroniser so they line up
    // Pins may change at any time; two flops bound the metastability risk
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_meta <= '0;
            pins_sync <= '0;
            pins_prev <= '0;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
            pins_prev <= pins_sync;
        end
    end

    // Edges, not levels, so a held pin fires once
    function automatic logic rising(input logic cur_level, input logic prev_level);
        return cur_level && !prev_level;
    endfunction

    wire logic writing = pins_sync.write_mode;
    wire logic read_char_ev = rising(pins_sync.read_strobe, pins_prev.read_strobe);
    wire logic check_char_ev = rising(pins_sync.check_strobe, pins_prev.check_strobe);
    wire logic gap_rise = rising(pins_sync.gap_check_timer, pins_prev.gap_check_timer);
    wire logic amp_rise = rising(pins_sync.amp_sense, pins_prev.amp_sense);
    wire logic [6:0] char_bits = pins_sync.read_char;

    // ==========================================================
    // Bus decode
    logic code_mode_select;
    logic [5:0] conv_mem_in;
    logic [5:0] conv_tape_in;
    logic [5:0] conv_tape_out;
    logic [5:0] conv_mem_out;
    logic [5:0] next_tape_out;
    logic [5:0] next_mem_out;
    logic capture_alt;
    logic [6:0] capture_bits;
    logic [6:0] write_data_acc;
    ted_pkg::ted_cause_t cause;
    logic err_active;
    logic amp_active;

    wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic bus_wr = bus_req && wb_we_i;
    // Full byte compare; aliases would hide misaddressed writes
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
        return adr == ofs;
    endfunction

    wire logic sel_ctrl = reg_hit(wb_adr_i, `TED_CTRL_OFS);
    wire logic sel_status = reg_hit(wb_adr_i, `TED_STATUS_OFS);
    wire logic sel_accum = reg_hit(wb_adr_i, `TED_ACCUM_OFS);
    wire logic sel_conv = reg_hit(wb_adr_i, `TED_CONV_OFS);
    wire logic wr_ctrl = bus_wr && sel_ctrl && wb_sel_i[0];
    wire logic wr_status = bus_wr && sel_status && wb_sel_i[0];
    wire logic wr_conv_mem = bus_wr && sel_conv && wb_sel_i[0];
    wire logic wr_conv_tape = bus_wr && sel_conv && wb_sel_i[1];

    // Start is a write-one strobe, never stored
    wire logic op_start = wr_ctrl && wb_dat_i[`TED_CTRL_START_BIT];

    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [31:0] accum_word;
    logic [31:0] conv_word;
    logic [31:0] rd_word;

    always_comb begin
        ctrl_word = '0;
        ctrl_word[`TED_CTRL_MODE_BIT] = code_mode_select;
        status_word = '0;
        status_word[`TED_STATUS_CAUSE_LSB +: 4] = cause;
        status_word[`TED_STATUS_ERR_BIT] = err_active;
        status_word[`TED_STATUS_AMP_BIT] = amp_active;
        status_word[`TED_STATUS_ALT_BIT] = capture_alt;
        accum_word = '0;
        accum_word[`TED_ACCUM_CAPT_LSB +: 7] = capture_bits;
        accum_word[`TED_ACCUM_WDATA_LSB +: 7] = write_data_acc;
        conv_word = '0;
        conv_word[`TED_CONV_MEM_IN_LSB +: 6] = conv_mem_in;
        conv_word[`TED_CONV_TAPE_IN_LSB +: 6] = conv_tape_in;
        conv_word[`TED_CONV_TAPE_OUT_LSB +: 6] = conv_tape_out;
        conv_word[`TED_CONV_MEM_OUT_LSB +: 6] = conv_mem_out;
    end

    // Unmapped offsets read as zero and still acknowledge
    assign rd_word = sel_ctrl ? ctrl_word :
                     sel_status ? status_word :
                     sel_accum ? accum_word :
                     sel_conv ? conv_word : 32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Zero outside ack so a stale word never looks valid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= bus_req ? rd_word : 32'h00000000;
        end
    end

    // ==========================================================
    // Mode select and conversion registers
    // mode bit held by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_mode_select <= `TED_MODE_RST;
        end else if (wr_ctrl) begin
            code_mode_select <= wb_dat_i[`TED_CTRL_MODE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_mem_in <= `TED_CODE_RST;
            conv_tape_in <= `TED_CODE_RST;
        end else begin
            if (wr_conv_mem) begin
                conv_mem_in <= wb_dat_i[`TED_CONV_MEM_IN_LSB +: 6];
            end
            if (wr_conv_tape) begin
                conv_tape_in <= wb_dat_i[`TED_CONV_TAPE_IN_LSB +: 6];
            end
        end
    end

    ted_code_conv u_conv (
        .decimal_i(code_mode_select),
        .mem_code_i(conv_mem_in),
        .tape_code_i(conv_tape_in),
        .tape_code_o(next_tape_out),
        .mem_code_o(next_mem_out)
    );

    // Results lag the inputs by one clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_tape_out <= `TED_CODE_RST;
        end else begin
            conv_tape_out <= next_tape_out;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_mem_out <= `TED_CODE_RST;
        end else begin
            conv_mem_out <= next_mem_out;
        end
    end

    // ==========================================================
    // Parity accumulators
    logic [6:0] next_capture_bits;
    logic [6:0] next_write_data_acc;
    logic next_capture_alt;

    assign next_capture_bits = op_start ? 7'h00 :
                               (writing && read_char_ev) ? capture_bits ^ char_bits : capture_bits;
    assign next_write_data_acc = op_start ? 7'h00 :
                                 (!writing && read_char_ev) ? write_data_acc ^ char_bits : write_data_acc;
    assign next_capture_alt = op_start ? 1'b0 :
                              (writing && check_char_ev && !code_mode_select) ? !capture_alt : capture_alt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_bits <= 7'h00;
        end else begin
            capture_bits <= next_capture_bits;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_data_acc <= 7'h00;
        end else begin
            write_data_acc <= next_write_data_acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_alt <= 1'b0;
        end else begin
            capture_alt <= next_capture_alt;
        end
    end

    // ==========================================================
    // Error conditions
    wire logic parity_tree_out = ^capture_bits;

    wire logic bin_char_err = !code_mode_select && !(parity_tree_out ^ capture_alt);
    wire logic dec_char_err = code_mode_select && parity_tree_out;
    wire logic write_char_ev = writing && check_char_ev && (bin_char_err || dec_char_err);

    wire logic read_lrc_ev = !writing && gap_rise && (write_data_acc != 7'h00);
    wire logic write_lrc_ev = writing && gap_rise && (capture_bits != 7'h00);
    wire logic amp_start = writing && amp_rise;

    wire logic err_trigger = read_lrc_ev || write_char_ev || write_lrc_ev || amp_start;

    // ==========================================================
    // Sticky causes, write one to clear
    ted_pkg::ted_cause_t cause_set;
    ted_pkg::ted_cause_t cause_clr;
    ted_pkg::ted_cause_t next_cause;

    assign cause_set.amplitude = amp_start;
    assign cause_set.write_lrc = write_lrc_ev;
    assign cause_set.write_char = write_char_ev;
    assign cause_set.read_lrc = read_lrc_ev;
    assign cause_clr = wr_status ? ted_pkg::ted_cause_t'(wb_dat_i[`TED_STATUS_CAUSE_LSB +: 4]) : '0;
    // A new event beats a clear in the same cycle
    assign next_cause = (cause & ~cause_clr) | cause_set;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause <= '0;
        end else begin
            cause <= next_cause;
        end
    end

    // ==========================================================
    // Timers
    // 10 us amplitude timer
    ted_oneshot #(
        .CYCLES(`TED_AMP_CYC)
    ) u_amp_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(amp_start),
        .active_o(amp_active)
    );

    // Retrigger stretches the pulse; the channel sees one long error
    // 10 us error pulse
    ted_oneshot #(
        .CYCLES(`TED_ERR_CYC)
    ) u_err_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(err_trigger),
        .active_o(err_active)
    );

    // Registered copies keep the pins one clock behind status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_pulse_o <= 1'b0;
        end else begin
            error_pulse_o <= err_active;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amplitude_error_timer_o <= 1'b0;
        end else begin
            amplitude_error_timer_o <= amp_active;
        end
    end

endmodule

// ### core/ted_oneshot.sv
// Retriggerable one-shot timer with a fixed pulse length.
// Assumes a synchronous active-high reset on the common clock.
`timescale 1ns/1ps
`include "ted_regs.svh"

module ted_oneshot #(
    parameter int CYCLES = `TED_ERR_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic active_o
);

    logic [`TED_TIMER_W-1:0] count;
    logic [`TED_TIMER_W-1:0] next_count;
    wire logic last_cycle = (count == `TED_TIMER_W'(CYCLES - 1));

    // Retrigger restarts the full length
    assign next_count = start_i ? `TED_TIMER_W'(0) :
                        (active_o && !last_cycle) ? count + `TED_TIMER_W'(1) : count;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
            active_o <= 1'b0;
        end else begin
            count <= next_count;
            active_o <= start_i ? 1'b1 : (last_cycle ? 1'b0 : active_o);
        end
    end

endmodule

// ### core/ted_pkg.sv
// Types shared by the tape error detector modules.
// Assumes nothing of its surroundings.
package ted_pkg;

    // ==========================================================
    // Pin group, passed through the synchroniser as one word
    typedef struct packed {
        logic write_mode;
        logic gap_check_timer;
        logic read_strobe;
        logic check_strobe;
        logic amp_sense;
        logic [6:0] read_char;
    } ted_pins_t;

    // ==========================================================
    // Sticky error causes
    typedef struct packed {
        logic amplitude;
        logic write_lrc;
        logic write_char;
        logic read_lrc;
    } ted_cause_t;

endpackage

// ### core/ted_regs.svh
// Register offsets, field positions, reset values and timing counts
// of the tape error detector.
// Assumes a 200 MHz clock and a byte-addressed Wishbone slave.
`ifndef TED_REGS_SVH
`define TED_REGS_SVH

// ==========================================================
// Register byte offsets
`define TED_CTRL_OFS 8'h00
`define TED_STATUS_OFS 8'h04
`define TED_ACCUM_OFS 8'h08
`define TED_CONV_OFS 8'h0C

// ==========================================================
// Field positions
`define TED_CTRL_MODE_BIT 0
`define TED_CTRL_START_BIT 1
`define TED_STATUS_CAUSE_LSB 0
`define TED_STATUS_ERR_BIT 8
`define TED_STATUS_AMP_BIT 9
`define TED_STATUS_ALT_BIT 10
`define TED_ACCUM_CAPT_LSB 0
`define TED_ACCUM_WDATA_LSB 8
`define TED_CONV_MEM_IN_LSB 0
`define TED_CONV_TAPE_IN_LSB 8
`define TED_CONV_TAPE_OUT_LSB 16
`define TED_CONV_MEM_OUT_LSB 24

// ==========================================================
// Reset values
`define TED_MODE_RST 1'b0
`define TED_CODE_RST 6'h00

// ==========================================================
// Code conversion constants
`define TED_MEM_ZERO 6'h00
`define TED_TAPE_ZERO 6'h0A
`define TED_ZONE_SWAP_BIT 5
`define TED_ZONE_SEL_BIT 4

// ==========================================================
// Timing
`define TED_CLK_MHZ 200
`define TED_ERR_US 10
`define TED_AMP_US 10
`define TED_ERR_CYC (`TED_ERR_US * `TED_CLK_MHZ)
`define TED_AMP_CYC (`TED_AMP_US * `TED_CLK_MHZ)
`define TED_TIMER_W 12

`endif

// ### verif/ted_buffer_channel.sv
// Model of the buffer channel that takes the error one-shot.
// Assumes the bench clock and a synchronous active-high reset.
`timescale 1ns/1ps

module ted_buffer_channel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic error_pulse_i,
    input wire logic char_strobe_i,
    input wire logic [6:0] char_i,
    output int pulse_count_o,
    output int last_width_o,
    output int bad_parity_o
);
    int run = 0;
    logic prev = 1'b0;
    logic prev_stb = 1'b0;

    always_ff @(posedge clk_i) begin
        prev <= error_pulse_i;
        prev_stb <= char_strobe_i;
        run <= error_pulse_i ? run + 1 : 0;
        if (rst_i) begin
            pulse_count_o <= 0;
            last_width_o <= 0;
            bad_parity_o <= 0;
        end else begin
            if (error_pulse_i && !prev) pulse_count_o <= pulse_count_o + 1;
            if (!error_pulse_i && prev) last_width_o <= run;
            if (char_strobe_i && !prev_stb && !(^char_i)) bad_parity_o <= bad_parity_o + 1;
        end
    end
endmodule

// ### verif/ted_error_detector_bench.sv
// Bench of the tape error detector against an integer model.
// Assumes the detector, its checker and the channel model.
`timescale 1ns/1ps

module ted_error_detector_bench;
    localparam int PULSE_CYC = 10 * 200;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic wmode = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] pins = 4'h0;
    logic [6:0] rchar = 7'h00;
    logic [31:0] rdat;
    logic ack, err, ampt;
    int pulses, width, bad_par, capt, wacc, alt, cause, dec, exp_pulses;
    int exp_bad = 0;
    int fails = 0;
    int n_compared = 0;
    int amp_run = 0;
    int amp_width = 0;
    int unsigned seed = 72;

    ted_error_detector ted_error_detector_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .write_mode_i(wmode), .gap_check_timer_i(pins[2]), .read_strobe_i(pins[0]), .check_strobe_i(pins[1]),
        .amp_sense_i(pins[3]), .read_char_i(rchar), .error_pulse_o(err), .amplitude_error_timer_o(ampt));
    ted_buffer_channel ted_buffer_channel_i (.clk_i(clk_i), .rst_i(rst_i), .error_pulse_i(err),
        .char_strobe_i(pins[0] & ~wmode), .char_i(rchar), .pulse_count_o(pulses), .last_width_o(width),
        .bad_parity_o(bad_par));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        amp_run <= ampt ? amp_run + 1 : 0;
        if (!ampt && amp_run != 0) amp_width <= amp_run;
    end

    // ==========
    // Helpers and model
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int conv(int d, int c, int z_in, int z_out);
        if (d == 0) return c;
        if (c == z_in) return z_out;
        return c[4] ? c ^ 32 : c;
    endfunction
    function automatic logic [6:0] pchar(int odd);
        logic [6:0] c;
        c = 7'(rnd());
        c[6] = ^c[5:0] ^ odd[0];
        return c;
    endfunction
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 100) begin
            cmp("bus ack", 32'h0000_0001, 32'h0000_0000);
            final_report();
        end
    endtask
    task automatic pulse(input int k);
        pins[k] <= 1'b1;
        hold(4);
        pins[k] <= 1'b0;
        hold(4);
    endtask
    task automatic flag(input int k);
        cause |= 1 << k;
        exp_pulses++;
    endtask
    task automatic send(input logic [6:0] c, input bit chk);
        rchar <= c;
        hold(2);
        pulse(0);
        if (wmode) capt ^= c;
        else wacc ^= c;
        if (!wmode && !(^c)) exp_bad++;
        if (chk) begin
            pulse(1);
            if (dec ? ^capt : (^capt) == alt[0]) flag(1);
            if (dec == 0) alt ^= 1;
        end
    endtask
    task automatic gap();
        pulse(2);
        if (wmode ? capt != 0 : wacc != 0) flag(wmode ? 2 : 0);
    endtask
    task automatic start(input int d, input logic w);
        logic [31:0] q;
        wmode <= w;
        dec = d;
        {capt, wacc, alt, cause} = '0;
        wb(1, 8'h00, 32'(d) | 32'h0000_0002, q);
        wb(1, 8'h04, 32'h0000_000F, q);
        wb(0, 8'h00, 32'h0000_0000, q);
        cmp("ctrl", 32'(d), q);
    endtask
    task automatic check_state();
        logic [31:0] q;
        hold(4);
        wb(0, 8'h04, 32'h0000_0000, q);
        cmp("status", 32'(alt << 10 | cause), q & 32'h0000_040F);
        wb(0, 8'h08, 32'h0000_0000, q);
        cmp("accum", 32'(wmode ? capt : wacc), wmode ? q & 32'h0000_007F : q >> 8 & 32'h0000_007F);
    endtask
    task automatic settle();
        hold(PULSE_CYC + 100);
        cmp("pulses", exp_pulses, pulses);
        if (exp_pulses > 0) cmp("width", PULSE_CYC, width);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========
    // Scenarios
    initial begin
        logic [31:0] q;
        int s;
        hold(3);
        rst_i <= 1'b0;
        for (int a = 0; a < 24; a += 4) begin
            if (a == 8 || a >= 16) wb(1, 8'(a), 32'hFFFF_FFFF, q);
            wb(0, 8'(a), 32'h0000_0000, q);
            cmp("register", 32'h0000_0000, q);
        end
        $display("test registers done");
        for (int d = 0; d < 2; d++) begin
            start(d, 1'b0);
            for (int m = 0; m < 64; m++) begin
                s = (m == 10) ? 10 : rnd() & 63;
                wb(1, 8'h0C, 32'(s << 8 | m), q);
                wb(0, 8'h0C, 32'h0000_0000, q);
                cmp("conv", 32'(conv(d, s, 10, 0) << 24 | conv(d, m, 0, 10) << 16 | s << 8 | m), q);
            end
        end
        $display("test conversion done");
        start(0, 1'b0);
        s = 0;
        repeat (4) begin
            s ^= rnd() & 127;
            send(7'(s ^ wacc), 1'b0);
        end
        send(7'(wacc), 1'b0);
        gap();
        check_state();
        send(7'(rnd() | 1), 1'b0);
        gap();
        check_state();
        settle();
        cmp("bad parity", exp_bad, bad_par);
        $display("test read lrc done");
        for (int d = 0; d < 2; d++) begin
            start(d, 1'b1);
            repeat (6) send(pchar(d == 0), 1'b1);
            check_state();
            send(pchar(d), 1'b1);
            check_state();
            settle();
            gap();
            check_state();
            settle();
        end
        $display("test write parity done");
        for (int w = 0; w < 2; w++) begin
            start(0, w[0]);
            pulse(3);
            if (w == 1) flag(3);
            check_state();
            settle();
            cmp("amp width", w ? PULSE_CYC : 0, amp_width);
        end
        $display("test amplitude done");
        final_report();
    end

    initial begin
        #(5 * 60000);
        fails++;
        final_report();
    end
endmodule

// ### verif/ted_error_detector_checker.sv
// Port-level assertions of the tape error detector.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module ted_error_detector_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic write_mode_i,
    input wire logic gap_check_timer_i,
    input wire logic read_strobe_i,
    input wire logic check_strobe_i,
    input wire logic amp_sense_i,
    input wire logic [6:0] read_char_i,
    input wire logic error_pulse_o,
    input wire logic amplitude_error_timer_o
);
    localparam int PULSE_CYC = 2000;
    int err_len;
    int amp_len;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ==========
    // Run lengths, so a short pulse shows at its fall
    always_ff @(posedge clk_i) begin
        err_len <= (rst_i || !error_pulse_o) ? 0 : err_len + 1;
        amp_len <= (rst_i || !amplitude_error_timer_o) ? 0 : amp_len + 1;
    end

    a_err_full_len: assert property (
        $fell(error_pulse_o) |-> err_len >= PULSE_CYC) else $error("error pulse too short");
    a_amp_full_len: assert property (
        $fell(amplitude_error_timer_o) |-> amp_len >= PULSE_CYC) else $error("amp timer too short");
    a_amp_err_pair: assert property (
        $rose(amplitude_error_timer_o) |-> ##[0:2] error_pulse_o) else $error("amp error not reported");
    a_amp_write_only: assert property (
        $rose(amplitude_error_timer_o) |-> write_mode_i) else $error("amp timer outside write");
    a_amp_timer_start: assert property (
        write_mode_i [*4] ##0 $rose(amp_sense_i) |-> ##[2:6] amplitude_error_timer_o)
        else $error("amp timer not started");
    a_quiet_after_reset: assert property (
        $fell(rst_i) |-> !error_pulse_o && !amplitude_error_timer_o && !wb_ack_o) else $error("busy after reset");
    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_next_edge: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_dat_quiet: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data without ack");
endmodule

bind ted_error_detector ted_error_detector_checker ted_error_detector_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .write_mode_i(write_mode_i), .gap_check_timer_i(gap_check_timer_i),
    .read_strobe_i(read_strobe_i), .check_strobe_i(check_strobe_i), .amp_sense_i(amp_sense_i),
    .read_char_i(read_char_i), .error_pulse_o(error_pulse_o),
    .amplitude_error_timer_o(amplitude_error_timer_o)
);
